// ===== irq_cpu_model.sv
// CPU-side partner: reset vector memory and first-instruction pulse
`timescale 1ns/1ps
`default_nettype none
module irq_cpu_model #(
    parameter logic [15:0] VEC = 16'h1a2c,
    parameter int INSN_CYCLES = 20
) (
    // Clock
    input wire logic mclk,
    // Vector fetch
    input wire logic vec_rd,
    input wire logic [15:0] vec_addr,
    output logic [7:0] vec_rdata = 8'h00,
    // Execution
    input wire logic cpu_running,
    output logic first_insn_done = 1'b0
);
    int cnt = 0;
    // Data valid only the cycle after a read; toggles else to expose late use
    always @(posedge mclk) begin
        if (vec_rd) begin
            vec_rdata <= (vec_addr == 16'h0000) ? VEC[15:8] : VEC[7:0];
        end else begin
            vec_rdata <= ~vec_rdata;
        end
    end
    // First instruction ends a while after execution starts
    always @(posedge mclk) begin
        cnt <= cpu_running ? cnt + 1 : 0;
        first_insn_done <= cpu_running && (cnt == INSN_CYCLES);
    end
endmodule
`default_nettype wire

// ===== irq_flags_and_reset_entry.sv
// Interrupt request flags, enables and reset exception entry
// Function
// - Direct transition by sleep with transition-on set sets flag bit 7.
// - Selected edge on pin three in interrupt mode sets bit 3.
// - Selected edge on pin zero in interrupt mode sets bit 0.
// - Timer overflow sets timer flag bit 5 until software writes 0.
// - Selected edge on wakeup pin five in interrupt mode sets bit 5.
// - First flag register reads bit 6, 2, 1 as 0, bits 5, 4 as 1.
// - Timer flag register reads bit 7 as 0, bits 4..0 as 1.
// - Wakeup flag register reads bits 7, 6 as 1, bits 4..0 as 0.
// - While reset pin is low, all processing halts in reset.
// - Reset puts every flag and control register to its initial value.
// - Reset release starts the reset exception sequence.
// - First step of reset entry sets the interrupt mask bit.
// - Vector fetched from 0000 and 0001, loaded into PC, execution starts.
// - A set flag requests an interrupt only when its enable is 1.
// - Edge select 0 picks falling edge, 1 picks rising edge.
// - No request, even non-maskable, until the first instruction executes.
`timescale 1ns/1ps
`default_nettype none
module irq_flags_and_reset_entry (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Event sources
    input wire logic sleep_direct_transition,
    input wire logic ext_interrupt_pin_three,
    input wire logic ext_interrupt_pin_zero,
    input wire logic wakeup_pin_five,
    input wire logic timer_overflow,
    // CPU side
    input wire logic first_insn_done,
    input wire logic [7:0] vec_rdata,
    output logic vec_rd,
    output logic [15:0] vec_addr,
    output logic pc_load,
    output logic [15:0] pc_value,
    output logic cpu_running,
    output logic imask_set,
    output logic irq_request,
    output logic nmi_allowed
);
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic [7:0] pin_flags_ff;
    logic timer_flag_ff;
    logic wake_flag_ff;
    logic [7:0] enables_one_ff;
    logic timer_overflow_enable_ff;
    logic [7:0] edge_select_ff;
    logic [7:0] pin_control_ff;
    logic p3_prev_ff;
    logic p0_prev_ff;
    logic wk_prev_ff;
    logic accept_ok_ff;
    logic irq_request_ff;
    logic [7:0] reg_rdata_ff;
    logic set_dt;
    logic set_p3;
    logic set_p0;
    logic set_tmr;
    logic set_wk;
    logic wr_pin;
    logic wr_tmr;
    logic wr_wake;
    logic any_pending;
    reset_entry_if re ();

    // Edge of interest: select 1 is rising, 0 is falling
    function automatic logic edge_seen(input logic prev, input logic cur,
        input logic sel);
        edge_seen = sel ? (!prev && cur) : (prev && !cur);
    endfunction

    // Keeps a flag, clears it only on a written 0, set has priority
    function automatic logic flag_next(input logic cur, input logic set,
        input logic wr, input logic wbit);
        flag_next = set || (cur && !(wr && !wbit));
    endfunction

    // Release of reset is synchronised; assertion stays asynchronous
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Pin history for edge detection; idle level is high
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            p3_prev_ff <= irq_pkg::PIN_IDLE;
            p0_prev_ff <= irq_pkg::PIN_IDLE;
            wk_prev_ff <= irq_pkg::PIN_IDLE;
        end else begin
            p3_prev_ff <= ext_interrupt_pin_three;
            p0_prev_ff <= ext_interrupt_pin_zero;
            wk_prev_ff <= wakeup_pin_five;
        end
    end

    // Set conditions for each flag
    always_comb begin
        set_dt = sleep_direct_transition &&
            pin_control_ff[irq_pkg::TRANSITION_ON_BIT];
        set_p3 = pin_control_ff[irq_pkg::P3_FN_BIT] &&
            edge_seen(p3_prev_ff, ext_interrupt_pin_three,
            edge_select_ff[irq_pkg::P3_BIT]);
        set_p0 = pin_control_ff[irq_pkg::P0_FN_BIT] &&
            edge_seen(p0_prev_ff, ext_interrupt_pin_zero,
            edge_select_ff[irq_pkg::P0_BIT]);
        set_tmr = timer_overflow;
        set_wk = pin_control_ff[irq_pkg::WK_FN_BIT] &&
            edge_seen(wk_prev_ff, wakeup_pin_five,
            edge_select_ff[irq_pkg::WK_BIT]);
    end

    // Write decode for the flag registers
    assign wr_pin = reg_wr && (reg_addr == irq_pkg::OFS_PIN_FLAGS);
    assign wr_tmr = reg_wr && (reg_addr == irq_pkg::OFS_TIMER_FLAGS);
    assign wr_wake = reg_wr && (reg_addr == irq_pkg::OFS_WAKE_FLAGS);

    // Request flags; only the three live bits of the first register store
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            pin_flags_ff <= irq_pkg::RST_BYTE;
            timer_flag_ff <= 1'b0;
            wake_flag_ff <= 1'b0;
        end else begin
            pin_flags_ff[irq_pkg::DT_BIT] <= flag_next(
                pin_flags_ff[irq_pkg::DT_BIT], set_dt, wr_pin,
                reg_wdata[irq_pkg::DT_BIT]);
            pin_flags_ff[irq_pkg::P3_BIT] <= flag_next(
                pin_flags_ff[irq_pkg::P3_BIT], set_p3, wr_pin,
                reg_wdata[irq_pkg::P3_BIT]);
            pin_flags_ff[irq_pkg::P0_BIT] <= flag_next(
                pin_flags_ff[irq_pkg::P0_BIT], set_p0, wr_pin,
                reg_wdata[irq_pkg::P0_BIT]);
            timer_flag_ff <= flag_next(timer_flag_ff, set_tmr, wr_tmr,
                reg_wdata[irq_pkg::TMR_BIT]);
            wake_flag_ff <= flag_next(wake_flag_ff, set_wk, wr_wake,
                reg_wdata[irq_pkg::WK_BIT]);
        end
    end

    // First enables, edge selects and pin control are plain read/write bytes; second enables stores bit 5 only
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            enables_one_ff <= irq_pkg::RST_BYTE;
            timer_overflow_enable_ff <= 1'b0;
            edge_select_ff <= irq_pkg::RST_BYTE;
            pin_control_ff <= irq_pkg::RST_BYTE;
        end else if (reg_wr) begin
            if (reg_addr == irq_pkg::OFS_ENABLES_ONE)
                enables_one_ff <= reg_wdata;
            if (reg_addr == irq_pkg::OFS_ENABLES_TWO)
                timer_overflow_enable_ff <= reg_wdata[irq_pkg::TMR_BIT];
            if (reg_addr == irq_pkg::OFS_EDGE_SELECT)
                edge_select_ff <= reg_wdata;
            if (reg_addr == irq_pkg::OFS_PIN_CONTROL)
                pin_control_ff <= reg_wdata;
        end
    end

    // Pending request: a flag gated by its own enable
    always_comb begin
        any_pending = (pin_flags_ff[irq_pkg::DT_BIT] &&
            enables_one_ff[irq_pkg::DT_BIT]) ||
            (pin_flags_ff[irq_pkg::P3_BIT] &&
            enables_one_ff[irq_pkg::P3_BIT]) ||
            (pin_flags_ff[irq_pkg::P0_BIT] &&
            enables_one_ff[irq_pkg::P0_BIT]) ||
            (wake_flag_ff && enables_one_ff[irq_pkg::WK_BIT]) ||
            (timer_flag_ff && timer_overflow_enable_ff);
    end

    // Acceptance stays closed until the first instruction has run, so
    // nothing can push the PC and condition codes before the stack
    // pointer has been set up
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            accept_ok_ff <= 1'b0;
            irq_request_ff <= 1'b0;
        end else begin
            if (first_insn_done && re.running)
                accept_ok_ff <= 1'b1;
            irq_request_ff <= any_pending && accept_ok_ff;
        end
    end

    // Read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            reg_rdata_ff <= irq_pkg::RST_BYTE;
        end else if (!reg_rd) begin
            reg_rdata_ff <= irq_pkg::RST_BYTE;
        end else begin
            case (reg_addr)
                irq_pkg::OFS_PIN_FLAGS:
                    reg_rdata_ff <= pin_flags_ff |
                        irq_pkg::PIN_FLAGS_ONES;
                irq_pkg::OFS_TIMER_FLAGS:
                    reg_rdata_ff <= {2'h0, timer_flag_ff, 5'h00} |
                        irq_pkg::TIMER_FLAGS_ONES;
                irq_pkg::OFS_WAKE_FLAGS:
                    reg_rdata_ff <= {2'h0, wake_flag_ff, 5'h00} |
                        irq_pkg::WAKE_FLAGS_ONES;
                irq_pkg::OFS_ENABLES_ONE:
                    reg_rdata_ff <= enables_one_ff;
                irq_pkg::OFS_ENABLES_TWO:
                    reg_rdata_ff <= {2'h0, timer_overflow_enable_ff,
                        5'h00} | irq_pkg::ENABLES_TWO_ONES;
                irq_pkg::OFS_EDGE_SELECT:
                    reg_rdata_ff <= edge_select_ff;
                irq_pkg::OFS_PIN_CONTROL:
                    reg_rdata_ff <= pin_control_ff;
                irq_pkg::OFS_STATUS:
                    reg_rdata_ff <= {5'h00, re.imask, accept_ok_ff,
                        re.running};
                default:
                    reg_rdata_ff <= irq_pkg::RST_BYTE;
            endcase
        end
    end

    // Reset entry sequencer
    assign re.vec_rdata = vec_rdata;
    reset_entry_seq u_seq (
        .mclk(mclk),
        .rst_sync_n(rst_sync_ff),
        .re(re)
    );

    // Outputs; the sequencer side is registered inside the sequencer
    assign reg_rdata = reg_rdata_ff;
    assign vec_rd = re.vec_rd;
    assign vec_addr = re.vec_addr;
    assign pc_load = re.pc_load;
    assign pc_value = re.pc_value;
    assign cpu_running = re.running;
    assign imask_set = re.imask;
    assign irq_request = irq_request_ff;
    assign nmi_allowed = accept_ok_ff;

    // Checks follow the synchronised reset, as the logic does
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_sync_ff);

    property p_dt_set;
        sleep_direct_transition && pin_control_ff[0] |=> pin_flags_ff[7];
    endproperty
    a_dt_set: assert property (p_dt_set)
        else $error("direct transition flag not set");

    property p_p3_set;
        pin_control_ff[1] && (edge_select_ff[3] ?
            $rose(ext_interrupt_pin_three) : $fell(ext_interrupt_pin_three))
            |=> pin_flags_ff[3];
    endproperty
    a_p3_set: assert property (p_p3_set)
        else $error("pin three edge missed");

    property p_p0_quiet;
        !pin_control_ff[2] && !pin_flags_ff[0] && !wr_pin
            |=> !pin_flags_ff[0];
    endproperty
    a_p0_quiet: assert property (p_p0_quiet)
        else $error("pin zero flag set while pin not in interrupt mode");

    property p_tmr_hold;
        timer_overflow ##1 !(wr_tmr && !reg_wdata[5]) [*3] |=> timer_flag_ff;
    endproperty
    a_tmr_hold: assert property (p_tmr_hold)
        else $error("timer flag lost without a clearing write");

    property p_wk_set;
        pin_control_ff[3] && (edge_select_ff[5] ?
            $rose(wakeup_pin_five) : $fell(wakeup_pin_five))
            |=> wake_flag_ff;
    endproperty
    a_wk_set: assert property (p_wk_set)
        else $error("wakeup edge missed");

    // Live flag bits are masked out; only the fixed bits are compared
    property p_fixed_bits;
        reg_rd |=> ($past(reg_addr) != 4'h0 ||
            (reg_rdata_ff & 8'h76) == 8'h30) &&
            ($past(reg_addr) != 4'h1 ||
            (reg_rdata_ff & 8'hdf) == 8'h1f) &&
            ($past(reg_addr) != 4'h2 ||
            (reg_rdata_ff & 8'hdf) == 8'hc0);
    endproperty
    a_fixed_bits: assert property (p_fixed_bits)
        else $error("reserved bits read wrong");

    property p_write_one;
        !pin_flags_ff[3] && wr_pin && reg_wdata[3] && !set_p3
            |=> !pin_flags_ff[3];
    endproperty
    a_write_one: assert property (p_write_one)
        else $error("writing one set a flag");

    property p_set_wins;
        wr_wake && !reg_wdata[5] && set_wk |=> wake_flag_ff;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a simultaneous set");

    property p_no_early_irq;
        !re.running |-> !irq_request_ff && !accept_ok_ff;
    endproperty
    a_no_early_irq: assert property (p_no_early_irq)
        else $error("request before first instruction");

    // Second cycle tolerates a clear that lands right after the request
    property p_gated;
        accept_ok_ff && timer_flag_ff && timer_overflow_enable_ff
            |=> irq_request_ff ##1 (irq_request_ff || !any_pending);
    endproperty
    a_gated: assert property (p_gated)
        else $error("enabled flag did not raise a request");

    c_timer_irq: cover property (set_tmr ##1 timer_flag_ff ##[1:20]
        irq_request_ff);
    c_clear: cover property (pin_flags_ff[0] ##1 !pin_flags_ff[0]);
    c_read_pin: cover property (reg_rd && reg_addr == 4'h0);
endmodule
`default_nettype wire

// ===== irq_flags_and_reset_entry_tb_top.sv
// Self-checking testbench for the request flags and reset entry block
`timescale 1ns/1ps
`default_nettype none
module irq_flags_and_reset_entry_tb_top;
    localparam logic [15:0] VEC = 16'h1a2c;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, sleep_dt = 1'b0, tmr_ovf = 1'b0;
    logic pin3 = 1'b1, pin0 = 1'b1, wake5 = 1'b1;
    logic [7:0] reg_rdata, vec_rdata;
    logic first_insn_done, vec_rd, pc_load, cpu_running;
    logic imask_set, irq_request, nmi_allowed;
    logic [15:0] vec_addr, pc_value;
    int failures = 0;
    int checks = 0;

    // 10 MHz clock
    always #50 mclk = ~mclk;

    irq_flags_and_reset_entry i_irq_flags_and_reset_entry (
        .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sleep_direct_transition(sleep_dt),
        .ext_interrupt_pin_three(pin3), .ext_interrupt_pin_zero(pin0),
        .wakeup_pin_five(wake5), .timer_overflow(tmr_ovf),
        .first_insn_done(first_insn_done), .vec_rdata(vec_rdata),
        .vec_rd(vec_rd), .vec_addr(vec_addr), .pc_load(pc_load),
        .pc_value(pc_value), .cpu_running(cpu_running),
        .imask_set(imask_set), .irq_request(irq_request),
        .nmi_allowed(nmi_allowed));

    irq_cpu_model #(.VEC(VEC)) i_irq_cpu_model (
        .mclk(mclk), .vec_rd(vec_rd), .vec_addr(vec_addr),
        .vec_rdata(vec_rdata), .cpu_running(cpu_running),
        .first_insn_done(first_insn_done));

    task automatic chk(input string name, input logic [15:0] exp,
        input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One-cycle write strobe, changed just after the edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
    endtask

    task automatic t_reset_entry;
        for (int i = 0; i < 60 && pc_load !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        chk("pc_load", 16'h1, {15'h0, pc_load});
        chk("pc_value", VEC, pc_value);
        chk("imask_set", 16'h1, {15'h0, imask_set});
        @(posedge mclk);
        #1;
        chk("cpu_running", 16'h1, {15'h0, cpu_running});
        chk("nmi_allowed", 16'h0, {15'h0, nmi_allowed});
        rdchk(irq_pkg::OFS_PIN_FLAGS, 8'h30);
        rdchk(irq_pkg::OFS_TIMER_FLAGS, 8'h1f);
        rdchk(irq_pkg::OFS_WAKE_FLAGS, 8'hc0);
        rdchk(irq_pkg::OFS_ENABLES_ONE, 8'h00);
        rdchk(irq_pkg::OFS_ENABLES_TWO, 8'h1f);
        // Running with the mask set, acceptance still closed
        rdchk(irq_pkg::OFS_STATUS, 8'h05);
        rdchk(4'h8, 8'h00);
        $display("test reset_entry done");
    endtask

    task automatic t_flags;
        wr(irq_pkg::OFS_PIN_CONTROL, 8'h0f);
        wr(irq_pkg::OFS_EDGE_SELECT, 8'h00);
        // Falling edges on all pins, a timer overflow and a sleep together
        @(posedge mclk);
        {pin3, pin0, wake5, tmr_ovf, sleep_dt} <= 5'b00011;
        @(posedge mclk);
        {tmr_ovf, sleep_dt} <= 2'b00;
        rdchk(irq_pkg::OFS_PIN_FLAGS, 8'hb9);
        rdchk(irq_pkg::OFS_TIMER_FLAGS, 8'h3f);
        rdchk(irq_pkg::OFS_WAKE_FLAGS, 8'he0);
        wr(irq_pkg::OFS_PIN_FLAGS, 8'hff);
        rdchk(irq_pkg::OFS_PIN_FLAGS, 8'hb9);
        // Mask bit is still set, so clearing is safe here
        wr(irq_pkg::OFS_PIN_FLAGS, 8'h00);
        wr(irq_pkg::OFS_WAKE_FLAGS, 8'h00);
        rdchk(irq_pkg::OFS_PIN_FLAGS, 8'h30);
        rdchk(irq_pkg::OFS_WAKE_FLAGS, 8'hc0);
        // Overflow in the very cycle of the clearing write
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= irq_pkg::OFS_TIMER_FLAGS;
        reg_wdata <= 8'h00;
        tmr_ovf <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        tmr_ovf <= 1'b0;
        rdchk(irq_pkg::OFS_TIMER_FLAGS, 8'h3f);
        $display("test flags done");
    endtask

    task automatic t_request;
        // Rising edges; wakeup pin not in interrupt mode, transition-on off
        wr(irq_pkg::OFS_PIN_CONTROL, 8'h06);
        wr(irq_pkg::OFS_EDGE_SELECT, 8'h29);
        @(posedge mclk);
        {pin3, pin0, wake5, sleep_dt} <= 4'b1111;
        @(posedge mclk);
        sleep_dt <= 1'b0;
        rdchk(irq_pkg::OFS_PIN_FLAGS, 8'h39);
        rdchk(irq_pkg::OFS_WAKE_FLAGS, 8'hc0);
        chk("nmi_allowed", 16'h1, {15'h0, nmi_allowed});
        chk("irq_request", 16'h0, {15'h0, irq_request});
        rdchk(irq_pkg::OFS_STATUS, 8'h07);
        wr(irq_pkg::OFS_ENABLES_ONE, 8'h08);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq_request", 16'h1, {15'h0, irq_request});
        wr(irq_pkg::OFS_PIN_FLAGS, 8'h01);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq_request", 16'h0, {15'h0, irq_request});
        wr(irq_pkg::OFS_ENABLES_TWO, 8'h20);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq_request", 16'h1, {15'h0, irq_request});
        $display("test request done");
    endtask

    task automatic t_mid_reset;
        @(posedge mclk);
        rst_n <= 1'b0;
        #1;
        chk("cpu_running", 16'h0, {15'h0, cpu_running});
        chk("irq_request", 16'h0, {15'h0, irq_request});
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset_entry();
        $display("test mid_reset done");
    endtask

    task automatic conclude;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Reset held 16 cycles, then the scenarios in turn
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset_entry();
        t_flags();
        t_request();
        t_mid_reset();
        conclude();
    end

    // Whole run needs well under 1000 cycles; cut a hang at 20000
    initial begin
        #2000000;
        failures++;
        conclude();
    end
endmodule
`default_nettype wire

// ===== irq_pkg.sv
// Constants shared by the request flag block and its reset entry sequencer
package irq_pkg;

    // Register index on the plain register port
    localparam logic [3:0] OFS_PIN_FLAGS = 4'h0;
    localparam logic [3:0] OFS_TIMER_FLAGS = 4'h1;
    localparam logic [3:0] OFS_WAKE_FLAGS = 4'h2;
    localparam logic [3:0] OFS_ENABLES_ONE = 4'h3;
    localparam logic [3:0] OFS_ENABLES_TWO = 4'h4;
    localparam logic [3:0] OFS_EDGE_SELECT = 4'h5;
    localparam logic [3:0] OFS_PIN_CONTROL = 4'h6;
    localparam logic [3:0] OFS_STATUS = 4'h7;

    // Flag bit positions
    localparam int DT_BIT = 7;
    localparam int P3_BIT = 3;
    localparam int P0_BIT = 0;
    localparam int TMR_BIT = 5;
    localparam int WK_BIT = 5;

    // Pin control bit positions
    localparam int TRANSITION_ON_BIT = 0;
    localparam int P3_FN_BIT = 1;
    localparam int P0_FN_BIT = 2;
    localparam int WK_FN_BIT = 3;

    // Fixed read values of the reserved bits
    localparam logic [7:0] PIN_FLAGS_ONES = 8'h30;
    localparam logic [7:0] TIMER_FLAGS_ONES = 8'h1f;
    localparam logic [7:0] WAKE_FLAGS_ONES = 8'hc0;
    localparam logic [7:0] ENABLES_TWO_ONES = 8'h1f;

    // Values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic PIN_IDLE = 1'b1;
    localparam logic [15:0] RST_PC = 16'h0000;

    // Reset vector location, high byte first
    localparam logic [15:0] VEC_ADDR_HI = 16'h0000;
    localparam logic [15:0] VEC_ADDR_LO = 16'h0001;

    // Reset entry sequencer states
    typedef enum logic [2:0] {
        SEQ_HOLD, SEQ_MASK, SEQ_FETCH_HI, SEQ_FETCH_LO, SEQ_TAKE_LO,
        SEQ_LOAD, SEQ_RUN
    } seq_state_t;

endpackage

// ===== reset_entry_if.sv
// Signals between the flag block and the reset entry sequencer
`timescale 1ns/1ps
`default_nettype none
interface reset_entry_if;
    logic imask;
    logic vec_rd;
    logic [15:0] vec_addr;
    logic [7:0] vec_rdata;
    logic pc_load;
    logic [15:0] pc_value;
    logic running;

    modport seq (output imask, output vec_rd, output vec_addr,
        input vec_rdata, output pc_load, output pc_value, output running);
    modport top (input imask, input vec_rd, input vec_addr,
        output vec_rdata, input pc_load, input pc_value, input running);
endinterface
`default_nettype wire

// ===== reset_entry_seq.sv
// Reset exception entry: sets the mask bit, fetches the vector, loads PC
`timescale 1ns/1ps
`default_nettype none
module reset_entry_seq (
    // Clock and synchronised reset
    input wire logic mclk,
    input wire logic rst_sync_n,
    // Link to the CPU side
    reset_entry_if.seq re
);
    irq_pkg::seq_state_t state_ff;
    logic [7:0] vec_hi_ff;

    // Sequence runs once after each reset release, then parks in run
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_ff <= irq_pkg::SEQ_HOLD;
        end else begin
            case (state_ff)
                irq_pkg::SEQ_HOLD: state_ff <= irq_pkg::SEQ_MASK;
                irq_pkg::SEQ_MASK: state_ff <= irq_pkg::SEQ_FETCH_HI;
                irq_pkg::SEQ_FETCH_HI: state_ff <= irq_pkg::SEQ_FETCH_LO;
                irq_pkg::SEQ_FETCH_LO: state_ff <= irq_pkg::SEQ_TAKE_LO;
                irq_pkg::SEQ_TAKE_LO: state_ff <= irq_pkg::SEQ_LOAD;
                irq_pkg::SEQ_LOAD: state_ff <= irq_pkg::SEQ_RUN;
                irq_pkg::SEQ_RUN: state_ff <= irq_pkg::SEQ_RUN;
                default: state_ff <= irq_pkg::SEQ_HOLD;
            endcase
        end
    end

    // Mask bit is forced on at the same edge as the first vector read strobe
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            re.imask <= 1'b0;
        end else if (state_ff == irq_pkg::SEQ_MASK) begin
            re.imask <= 1'b1;
        end
    end

    // Vector reads; memory answers one cycle after the strobe
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            re.vec_rd <= 1'b0;
            re.vec_addr <= irq_pkg::VEC_ADDR_HI;
            vec_hi_ff <= irq_pkg::RST_BYTE;
        end else begin
            re.vec_rd <= (state_ff == irq_pkg::SEQ_MASK) ||
                (state_ff == irq_pkg::SEQ_FETCH_HI);
            if (state_ff == irq_pkg::SEQ_MASK)
                re.vec_addr <= irq_pkg::VEC_ADDR_HI;
            else if (state_ff == irq_pkg::SEQ_FETCH_HI)
                re.vec_addr <= irq_pkg::VEC_ADDR_LO;
            if (state_ff == irq_pkg::SEQ_FETCH_LO)
                vec_hi_ff <= re.vec_rdata;
        end
    end

    // PC load pulse and run flag
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            re.pc_load <= 1'b0;
            re.pc_value <= irq_pkg::RST_PC;
            re.running <= 1'b0;
        end else begin
            re.pc_load <= (state_ff == irq_pkg::SEQ_TAKE_LO);
            if (state_ff == irq_pkg::SEQ_TAKE_LO)
                re.pc_value <= {vec_hi_ff, re.vec_rdata};
            if (state_ff == irq_pkg::SEQ_LOAD)
                re.running <= 1'b1;
        end
    end

    property p_mask_first;
        @(posedge mclk) disable iff (!rst_sync_n)
        $rose(re.vec_rd) |-> re.imask;
    endproperty
    a_mask_first: assert property (p_mask_first)
        else $error("vector fetched before mask bit set");

    property p_vec_order;
        @(posedge mclk) disable iff (!rst_sync_n)
        $rose(re.vec_rd) |-> re.vec_addr == 16'h0000
            ##1 re.vec_rd && re.vec_addr == 16'h0001 ##1 !re.vec_rd
            ##1 re.pc_load;
    endproperty
    a_vec_order: assert property (p_vec_order)
        else $error("reset vector fetch out of order");

    property p_entry_bound;
        @(posedge mclk) disable iff (!rst_sync_n)
        state_ff == irq_pkg::SEQ_HOLD |-> ##[1:6] re.pc_load;
    endproperty
    a_entry_bound: assert property (p_entry_bound)
        else $error("reset entry did not load PC in time");

    c_entry: cover property (@(posedge mclk) disable iff (!rst_sync_n)
        re.pc_load ##1 re.running);
endmodule
`default_nettype wire
